// ===== dv/phc_assertions.sv
// Checker: port-level assertions for the handshake controller
`timescale 1ns/1ps
`default_nettype none
module phc_assertions
  import phc_pkg::*;
#(
  parameter int unsigned WIDTH = PHC_WIDTH
) (
  input wire logic             core_clk,
  input wire logic             reset,
  input wire logic             clk_en,
  input wire logic [7:0]       paddr,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] pin_pullup,
  input wire logic [WIDTH-1:0] af_out,
  input wire logic [WIDTH-1:0] af_in,
  input wire phc_strobe_t      strobe_pins,
  input wire phc_ready_t       ready_pins,
  input wire phc_strobe_t      strobe_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////
  logic [3:0]       ctrl;
  logic [WIDTH-1:0] c0;
  logic [WIDTH-1:0] c1;
  logic [6:0]       since;
  // Shadow of the mode and pin config, taken at the same edge as the slave
  wire acc = clk_en & psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire rd_acc = acc & ~pwrite & (paddr == PHC_ADDR_DATA);
  wire done = pready & psel & (paddr == PHC_ADDR_DATA);
  wire in2 = ctrl == {1'b0, PHC_MODE_IN2};
  wire out2 = ctrl == {1'b0, PHC_MODE_OUT2};
  wire in1 = ctrl == {1'b0, PHC_MODE_IN1};
  wire out1 = ctrl == {1'b0, PHC_MODE_OUT1};
  wire bid = ctrl[3];
  wire none = ~(bid | in2 | out2 | in1 | out1);
  wire irdy = ready_pins.input_space_ready_line;
  wire ov = ready_pins.output_data_valid_line;
  wire taken = strobe_pins.output_taken_strobe;
  wire [WIDTH-1:0] af_m = c1 & c0;
  wire [WIDTH-1:0] bd_m = ~c1 & ~c0;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl <= PHC_CTRL_RESET;
      c0   <= PHC_CFG_RESET;
      c1   <= PHC_CFG_RESET;
    end else if (wr) begin
      if (paddr == PHC_ADDR_CTRL) ctrl <= pwdata[3:0];
      if (paddr == PHC_ADDR_CFG0) c0 <= pwdata[WIDTH-1:0];
      if (paddr == PHC_ADDR_CFG1) c1 <= pwdata[WIDTH-1:0];
    end
  end
  // Enabled cycles since reset release, saturating
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) since <= 7'h00;
    else if (clk_en && since < 7'h40) since <= since + 7'h01;
  end
  //////////////////////////////////////////////////////////////////////////
  // Margin of four cycles below the settle span keeps this safe
  a_settle_undriven: assert property (since < 7'h3c |->
    pin_oe == '0 && pin_pullup == '1) else $error("pins driven early");
  a_strobe_to_irq: assert property ((clk_en && $stable(strobe_pins))[*8] |->
    strobe_irq == strobe_pins) else $error("strobe not routed");
  a_idle_lines_high: assert property (none[*4] |->
    ready_pins == 2'b11) else $error("idle lines not high");
  a_load_drops_ready: assert property (in2 && irdy &&
    $rose(strobe_pins.input_load_strobe) |-> ##[3:8] !irdy)
    else $error("load edge kept ready");
  a_read_raises_ready: assert property ((in2 || bid) && done && !pwrite
    |-> ##[0:2] irdy) else $error("read did not raise ready");
  a_one_line_dip: assert property (in1 && rd_acc |->
    ##[0:2] !irdy ##[1:3] irdy) else $error("no read dip");
  a_write_sets_valid: assert property ((out2 || bid) && done && pwrite
    |-> ##[0:2] ov) else $error("write did not set valid");
  a_valid_holds: assert property ((out2 && taken)[*8] ##0 ov |=> ov)
    else $error("valid dropped without taken edge");
  a_bid_tristate: assert property ((bid && taken)[*8] |->
    (pin_oe & bd_m) == '0) else $error("bidir pins driven");
  a_af_loopback: assert property ($past(clk_en) |->
    (af_in & $past(af_m)) == ($past(af_out) & $past(af_m)))
    else $error("alternate output not looped back");
  c_load: cover property (in2 && $rose(strobe_pins.input_load_strobe));
  c_bid_take: cover property (bid && !taken && ov);
  c_out1_dip: cover property (out1 && !ov);
endmodule
bind phc_top phc_assertions #(.WIDTH(WIDTH)) i_phc_assertions (
  .core_clk, .reset, .clk_en, .paddr, .psel, .penable, .pwrite, .pwdata,
  .pready, .pin_oe, .pin_pullup, .af_out, .af_in, .strobe_pins,
  .ready_pins, .strobe_irq);
`default_nettype wire

// ===== dv/phc_periph.sv
// Partner: external peripheral trading data by strobes
`timescale 1ns/1ps
`default_nettype none
module phc_periph
  import phc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire phc_ready_t ready_pins,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  output phc_strobe_t     strobe_pins,
  output logic [7:0]      pin_in
);
  logic [7:0] d;
  logic       en;
  logic [7:0] got;
  logic [7:0] got_oe;
  logic [7:0] seen;
  logic       ov_q;
  initial begin
    strobe_pins = 2'b11;
    en = 1'b0;
    d = 8'h00;
  end
  // Wire level: device, then us, then pull-up, else a flipped last value
  always_comb begin
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : en ? d[i] : pin_pullup[i] | ~d[i];
  end
  // Latch the port as the valid line rises
  always @(posedge core_clk) begin
    ov_q <= ready_pins.output_data_valid_line;
    if (ready_pins.output_data_valid_line && !ov_q) seen <= pin_in;
  end
  //////////////////////////////////////////////////////////////////////////
  // The load strobe is held low three cycles and high six, above the filter minimum of two
  task automatic load(input logic [7:0] v);
    @(posedge core_clk);
    d <= v;
    en <= 1'b1;
    strobe_pins.input_load_strobe <= 1'b0;
    repeat (3) @(posedge core_clk);
    strobe_pins.input_load_strobe <= 1'b1;
    repeat (6) @(posedge core_clk);
    en <= 1'b0;
  endtask
  task automatic take();
    @(posedge core_clk);
    strobe_pins.output_taken_strobe <= 1'b0;
    repeat (8) @(posedge core_clk);
    got = pin_in;
    got_oe = pin_oe;
    strobe_pins.output_taken_strobe <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic drive(input logic e, input logic [7:0] v);
    @(posedge core_clk);
    en <= e;
    d <= v;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Testbench: APB-driven handshake scenarios for the port controller
`timescale 1ns/1ps
`default_nettype none
module tb
  import phc_pkg::*;
;
  logic        core_clk;
  logic        reset;
  logic        clk_en;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic [7:0]  pin_pullup;
  logic [7:0]  af_out;
  logic [7:0]  af_in;
  phc_strobe_t strobe_pins;
  phc_ready_t  ready_pins;
  phc_strobe_t strobe_irq;
  int          miscompares;
  int          check_count;
  int          in_lo;
  int          ov_lo;
  int          n0;
  phc_top i_phc_top (.core_clk, .reset, .clk_en, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
    .pin_pullup, .af_out, .af_in, .strobe_pins, .ready_pins, .strobe_irq);
  phc_periph i_phc_periph (.core_clk, .ready_pins, .pin_out, .pin_oe,
    .pin_pullup, .strobe_pins, .pin_in);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Count low cycles on each ready line so short dips are not missed
  always @(posedge core_clk) begin
    if (ready_pins.input_space_ready_line === 1'b0) in_lo++;
    if (ready_pins.output_data_valid_line === 1'b0) ov_lo++;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer; waits for pready, which only the watchdog bounds
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk(e, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk(e, xe);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    cyc(5000);
    miscompares++;
    tally_and_finish();
  end
  // Main sequence; bit 0 stays an output to show it is left alone
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    af_out = 8'hff;
    cyc(8);
    chk(ready_pins, 2'b11);
    chk(pin_oe, 8'h00);
    chk(pin_pullup, 8'hff);
    reset <= 1'b0;
    cyc(70);
    chk(strobe_irq, 2'b11);
    chk(ready_pins, 2'b11);
    wr(PHC_ADDR_CFG1, 32'h01);
    wr(PHC_ADDR_DATA, 32'hff); // Ones: bidir pins only pull up
    wr(PHC_ADDR_CTRL, {29'h0, PHC_MODE_IN2});
    cyc(4);
    chk(ready_pins.input_space_ready_line, 1'b1);
    i_phc_periph.load(8'h5a);
    cyc(3);
    chk(ready_pins.input_space_ready_line, 1'b0);
    i_phc_periph.load(8'h33);
    rd(PHC_ADDR_DATA, 32'h5b, 1'b0);
    cyc(3);
    chk(ready_pins.input_space_ready_line, 1'b1);
    wr(PHC_ADDR_CTRL, {29'h0, PHC_MODE_IN1});
    i_phc_periph.drive(1'b1, 8'hc2);
    cyc(8);
    n0 = in_lo;
    rd(PHC_ADDR_DATA, 32'hc3, 1'b0);
    cyc(3);
    chk(in_lo > n0, 1'b1);
    chk(ready_pins.input_space_ready_line, 1'b1);
    i_phc_periph.drive(1'b0, 8'hc3);
    wr(PHC_ADDR_CTRL, 32'h7);
    cyc(4);
    chk(ready_pins, 2'b11);
    wr(PHC_ADDR_CTRL, {29'h0, PHC_MODE_OUT2});
    cyc(4);
    chk(ready_pins.output_data_valid_line, 1'b0);
    wr(PHC_ADDR_DATA, 32'h96);
    cyc(12);
    chk(ready_pins.output_data_valid_line, 1'b1);
    chk(i_phc_periph.seen, 8'h96);
    i_phc_periph.take();
    chk(i_phc_periph.got, 8'h96);
    cyc(6);
    chk(ready_pins.output_data_valid_line, 1'b0);
    wr(PHC_ADDR_CTRL, {29'h0, PHC_MODE_OUT1});
    wr(PHC_ADDR_DATA, 32'h3c);
    cyc(4);
    n0 = ov_lo;
    wr(PHC_ADDR_DATA, 32'h3d);
    cyc(4);
    chk(ov_lo > n0, 1'b1);
    chk(ready_pins.output_data_valid_line, 1'b1);
    chk(pin_out, 8'h3d);
    wr(PHC_ADDR_CTRL, 32'h8);
    cyc(4);
    chk(ready_pins, 2'b01);
    chk(pin_oe[7:1], 7'h00);
    wr(PHC_ADDR_DATA, 32'ha7);
    cyc(12);
    chk(ready_pins, 2'b11);
    chk(pin_oe[7:1], 7'h00);
    i_phc_periph.take();
    chk(i_phc_periph.got, 8'ha7);
    chk(i_phc_periph.got_oe[7:1], 7'h7f);
    cyc(6);
    chk(ready_pins, 2'b01);
    chk(pin_oe[7:1], 7'h00);
    i_phc_periph.load(8'h68);
    cyc(3);
    chk(ready_pins.input_space_ready_line, 1'b0);
    rd(PHC_ADDR_DATA, 32'h69, 1'b0);
    wr(PHC_ADDR_CFG0, 32'hf0);
    wr(PHC_ADDR_CFG1, 32'hf1);
    af_out <= 8'h5a;
    cyc(4);
    chk(af_in[7:4], 4'h5);
    // Clock enable low must freeze the loopback register
    clk_en <= 1'b0;
    af_out <= 8'ha5;
    cyc(4);
    chk(af_in[7:4], 4'h5);
    clk_en <= 1'b1;
    cyc(4);
    chk(af_in[7:4], 4'ha);
    rd(8'h1c, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== hw/phc_pkg.sv
// Package: register map, modes, pin configuration codes for the handshake port
package phc_pkg;
  localparam int unsigned PHC_WIDTH = 8;
  // Register byte addresses
  localparam logic [7:0] PHC_ADDR_DATA   = 8'h00; // Port data: write=master latch
  localparam logic [7:0] PHC_ADDR_CFG2   = 8'h04;
  localparam logic [7:0] PHC_ADDR_CFG1   = 8'h08;
  localparam logic [7:0] PHC_ADDR_CFG0   = 8'h0c;
  localparam logic [7:0] PHC_ADDR_CTRL   = 8'h10; // Mode bits, bidir enable
  localparam logic [7:0] PHC_ADDR_STATUS = 8'h14; // Ready lines, strobe levels
  localparam logic [7:0] PHC_ADDR_PINS   = 8'h18; // Synchronised, filtered pin image
  // Control field positions
  localparam int unsigned PHC_CTRL_MODE_LO = 0;
  localparam int unsigned PHC_CTRL_MODE_HI = 2;
  localparam int unsigned PHC_CTRL_BIDIR   = 3;
  // Reset values: all bits bidirectional weak pull-up, no handshake
  localparam logic [7:0] PHC_CFG_RESET  = 8'h00;
  localparam logic [3:0] PHC_CTRL_RESET = 4'h0;
  localparam logic [7:0] PHC_DATA_RESET = 8'hff;
  // Number of clock cycles pins may stay undriven after reset release
  localparam int unsigned PHC_RESET_SETTLE = 64;
  // Handshake mode codes {hi, mid, lo}
  localparam logic [2:0] PHC_MODE_IN2  = 3'b101;
  localparam logic [2:0] PHC_MODE_OUT2 = 3'b110;
  localparam logic [2:0] PHC_MODE_IN1  = 3'b001;
  localparam logic [2:0] PHC_MODE_OUT1 = 3'b010;

  typedef enum logic [2:0] {
    PHC_HS_NONE, PHC_HS_IN2, PHC_HS_OUT2, PHC_HS_IN1, PHC_HS_OUT1, PHC_HS_BID
  } phc_hs_t;

  // Handshake ready lines and strobe inputs grouped together
  typedef struct packed {
    logic output_data_valid_line;
    logic input_space_ready_line;
  } phc_ready_t;

  typedef struct packed {
    logic output_taken_strobe;
    logic input_load_strobe;
  } phc_strobe_t;
endpackage

// ===== hw/phc_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module phc_sync
  import phc_pkg::*;
#(
  parameter logic INIT = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);
  logic s1;
  logic s2;
  logic s3;

  // First stage feeds only the second; level moves once stages two and three agree
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s1    <= INIT;
      s2    <= INIT;
      s3    <= INIT;
      level <= INIT;
      rise  <= 1'b0;
    end else if (clk_en) begin
      s1   <= pin_in;
      s2   <= s1;
      s3   <= s2;
      rise <= 1'b0;
      if (s2 == s3) begin
        level <= s3;
        rise  <= s3 & ~level;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/phc_top.sv
// Port handshake controller with APB register slave and pin drive logic
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// - Reset forces all pins weak pull-up bidirectional
// - Memory ports as I/O share same states
// - Two ready outputs, two strobe inputs
// - Strobes also routed to interrupt channels
// - Ready lines held high when idle
// - Input modes touch only input/bidir bits
// - Two-line input: ready on entry, latch
// - Load edge drops ready until port read
// - One-line input: low during port read
// - Output modes touch only output/bidir bits
// - Two-line output: clear on entry, set write
// - Valid stays high until taken edge
// - One-line output: low while latches written
// - Bidir mode turns weak pull-up push-pull
// - Bidir entry: tristate, ready set, valid clear
// - Bidir drives only while taken strobe low
// - Alternate output feeds alternate inputs too
// - Decode three mode bits to modes
module phc_top
  import phc_pkg::*;
#(
  parameter int unsigned WIDTH = PHC_WIDTH
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [WIDTH-1:0]  pin_in,
  output logic      [WIDTH-1:0]  pin_out,
  output logic      [WIDTH-1:0]  pin_oe,
  output logic      [WIDTH-1:0]  pin_pullup,
  input  wire logic [WIDTH-1:0]  af_out,
  output logic      [WIDTH-1:0]  af_in,
  input  wire phc_strobe_t       strobe_pins,
  output phc_ready_t             ready_pins,
  output phc_strobe_t            strobe_irq
);
  if (WIDTH < 1 || WIDTH > 8) begin : g_width_check
    $error("WIDTH must be 1..8");
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers and internal state
  logic [WIDTH-1:0] cfg2;
  logic [WIDTH-1:0] cfg1;
  logic [WIDTH-1:0] cfg0;
  logic [WIDTH-1:0] master_latch;
  logic [WIDTH-1:0] slave_latch;
  logic [WIDTH-1:0] input_latch;
  logic [WIDTH-1:0] pin_sync1;
  logic [WIDTH-1:0] pin_sync2;
  logic [WIDTH-1:0] pin_sync3;
  logic [WIDTH-1:0] pin_stable;
  logic [3:0]       ctrl;
  phc_hs_t          hs_mode;
  phc_hs_t          hs_prev;
  logic             in_ready;
  logic             out_valid;
  logic             bid_drive;
  logic             write_q;
  logic [6:0]       settle_cnt;
  logic             load_level;
  logic             load_rise;
  logic             taken_level;
  logic             taken_rise;
  logic             port_read;
  logic             port_write;
  logic             apb_access;
  logic             mode_entry;

  //////////////////////////////////////////////////////////////////////////
  // Strobe synchronisers
  phc_sync #(.INIT(1'b1)) u_sync_load (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .pin_in   (strobe_pins.input_load_strobe),
    .level    (load_level),
    .rise     (load_rise)
  );

  phc_sync #(.INIT(1'b1)) u_sync_taken (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .pin_in   (strobe_pins.output_taken_strobe),
    .level    (taken_level),
    .rise     (taken_rise)
  );

  //////////////////////////////////////////////////////////////////////////
  // Mode decode; bidirectional enable takes priority over the three bits
  always_comb begin
    hs_mode = PHC_HS_NONE;
    if (ctrl[PHC_CTRL_BIDIR]) begin
      hs_mode = PHC_HS_BID;
    end else begin
      case (ctrl[PHC_CTRL_MODE_HI:PHC_CTRL_MODE_LO])
        PHC_MODE_IN2:  hs_mode = PHC_HS_IN2;
        PHC_MODE_OUT2: hs_mode = PHC_HS_OUT2;
        PHC_MODE_IN1:  hs_mode = PHC_HS_IN1;
        PHC_MODE_OUT1: hs_mode = PHC_HS_OUT1;
        default:       hs_mode = PHC_HS_NONE;
      endcase
    end
  end

  assign apb_access = psel & penable & ~pready;
  assign port_read  = apb_access & ~pwrite & (paddr == PHC_ADDR_DATA);
  assign port_write = apb_access & pwrite & (paddr == PHC_ADDR_DATA);
  assign mode_entry = (hs_mode != hs_prev);

  //////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, pready pulses on the second access cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= apb_access;
      pslverr <= 1'b0;
      if (apb_access) begin
        pslverr <= (paddr > PHC_ADDR_PINS) | (paddr[1:0] != 2'b00);
        prdata  <= 32'h0000_0000;
        if (!pwrite) begin
          case (paddr)
            PHC_ADDR_DATA:   prdata[WIDTH-1:0] <= input_latch;
            PHC_ADDR_CFG2:   prdata[WIDTH-1:0] <= cfg2;
            PHC_ADDR_CFG1:   prdata[WIDTH-1:0] <= cfg1;
            PHC_ADDR_CFG0:   prdata[WIDTH-1:0] <= cfg0;
            PHC_ADDR_CTRL:   prdata[3:0] <= ctrl;
            PHC_ADDR_STATUS: prdata[3:0] <= {taken_level, load_level,
                                             out_valid, in_ready};
            PHC_ADDR_PINS:   prdata[WIDTH-1:0] <= pin_stable;
            default:         prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Configuration writes; reset puts every bit in weak pull-up bidir
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg2 <= WIDTH'(PHC_CFG_RESET);
      cfg1 <= WIDTH'(PHC_CFG_RESET);
      cfg0 <= WIDTH'(PHC_CFG_RESET);
      ctrl <= PHC_CTRL_RESET;
      master_latch <= WIDTH'(PHC_DATA_RESET);
    end else if (clk_en && apb_access && pwrite) begin
      case (paddr)
        PHC_ADDR_DATA: master_latch <= pwdata[WIDTH-1:0];
        PHC_ADDR_CFG2: cfg2 <= pwdata[WIDTH-1:0];
        PHC_ADDR_CFG1: cfg1 <= pwdata[WIDTH-1:0];
        PHC_ADDR_CFG0: cfg0 <= pwdata[WIDTH-1:0];
        PHC_ADDR_CTRL: ctrl <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin data synchroniser; first stage read only by the second
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_sync1  <= '1;
      pin_sync2  <= '1;
      pin_sync3  <= '1;
      pin_stable <= '1;
    end else if (clk_en) begin
      pin_sync1 <= pin_in;
      pin_sync2 <= pin_sync1;
      pin_sync3 <= pin_sync2;
      for (int i = 0; i < WIDTH; i++) begin
        if (pin_sync2[i] == pin_sync3[i]) pin_stable[i] <= pin_sync3[i];
      end
    end
  end

  // Settle counter: pins stay undriven right after reset release
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      settle_cnt <= 7'h00;
    end else if (clk_en && settle_cnt < 7'(PHC_RESET_SETTLE)) begin
      settle_cnt <= settle_cnt + 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode tracking for entry detection
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hs_prev <= PHC_HS_NONE;
    end else if (clk_en) begin
      hs_prev <= hs_mode;
    end
  end

  // Input-space-ready line; a load edge in the read cycle wins over the read only while ready is high
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      in_ready <= 1'b1;
    end else if (clk_en) begin
      case (hs_mode)
        PHC_HS_IN2, PHC_HS_BID: begin
          if (mode_entry) in_ready <= 1'b1;
          else if (load_rise && in_ready) in_ready <= 1'b0;
          else if (port_read) in_ready <= 1'b1;
        end
        PHC_HS_IN1: in_ready <= ~port_read;
        default:    in_ready <= 1'b1;
      endcase
    end
  end

  // Output-data-valid line and bidirectional output window
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b1;
      bid_drive <= 1'b0;
      write_q   <= 1'b0;
    end else if (clk_en) begin
      bid_drive <= 1'b0;
      // Set with the master latch load, so valid rises with the slave latch and never leads the pin data
      write_q   <= port_write;
      case (hs_mode)
        PHC_HS_OUT2, PHC_HS_BID: begin
          if (mode_entry) out_valid <= 1'b0;
          else if (write_q) out_valid <= 1'b1;
          else if (taken_rise) out_valid <= 1'b0;
          if (hs_mode == PHC_HS_BID)
            bid_drive <= ~taken_level & ~mode_entry;
        end
        PHC_HS_OUT1: out_valid <= ~write_q;
        default:     out_valid <= 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Input latch: per-bit; input or bidir bits follow the handshake, others load master or pin
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      input_latch <= '1;
    end else if (clk_en) begin
      for (int i = 0; i < WIDTH; i++) begin
        // Input or bidir bits: cfg1 low; output bits mirror the master
        if (!cfg1[i]) begin
          case (hs_mode)
            PHC_HS_IN2, PHC_HS_BID: begin
              // Sample while strobe low, freeze once latched
              if (in_ready && !load_level) input_latch[i] <= pin_stable[i];
            end
            PHC_HS_IN1: begin
              if (!port_read) input_latch[i] <= pin_stable[i];
            end
            default: input_latch[i] <= pin_stable[i];
          endcase
        end else if (!cfg0[i]) begin
          input_latch[i] <= master_latch[i];
        end else begin
          input_latch[i] <= pin_stable[i]; // Alternate function: read pin
        end
      end
    end
  end

  // Slave latch: handshake modes copy only output or bidir bits
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      slave_latch <= '1;
    end else if (clk_en) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (!cfg0[i]) slave_latch[i] <= master_latch[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drivers; cfg {2,1,0}: x00 bid, x10 out, x01 in, x11 alt func
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_out    <= '1;
      pin_oe     <= '0;
      pin_pullup <= '1;
    end else if (clk_en) begin
      for (int i = 0; i < WIDTH; i++) begin
        pin_out[i]    <= 1'b1;
        pin_oe[i]     <= 1'b0;
        pin_pullup[i] <= 1'b0;
        if (settle_cnt < 7'(PHC_RESET_SETTLE)) begin
          pin_pullup[i] <= 1'b1;
        end else begin
          case ({cfg1[i], cfg0[i]})
            2'b00: begin
              pin_out[i] <= slave_latch[i];
              if (hs_mode == PHC_HS_BID) begin
                // Weak pull-up becomes push-pull; open drain kept
                if (!cfg2[i]) pin_oe[i] <= bid_drive;
                else pin_oe[i] <= bid_drive & ~slave_latch[i];
              end else if (!cfg2[i]) begin
                pin_pullup[i] <= slave_latch[i];
                pin_oe[i]     <= ~slave_latch[i];
              end else begin
                pin_oe[i] <= ~slave_latch[i];
              end
            end
            2'b10: begin
              pin_out[i] <= slave_latch[i];
              pin_oe[i]  <= cfg2[i] ? ~slave_latch[i] : 1'b1;
            end
            2'b11: begin
              pin_out[i] <= af_out[i];
              pin_oe[i]  <= cfg2[i] ? ~af_out[i] : 1'b1;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Alternate inputs see the pin, or the alternate output driving it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      af_in <= '1;
    end else if (clk_en) begin
      for (int i = 0; i < WIDTH; i++) begin
        af_in[i] <= (cfg1[i] & cfg0[i]) ? af_out[i] : pin_stable[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Ready lines, idle high so shared alternate outputs can AND onto the pin
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ready_pins <= '1;
      strobe_irq <= '1; // Idle strobe level, so no false edge on release
    end else if (clk_en) begin
      ready_pins.input_space_ready_line <= in_ready;
      ready_pins.output_data_valid_line <= out_valid;
      // Synchronised levels go to the external interrupt channels
      strobe_irq.input_load_strobe   <= load_level;
      strobe_irq.output_taken_strobe <= taken_level;
    end
  end
endmodule
`default_nettype wire
